// >>> atcp_core.sv
// Purpose: Command parser, status framer and byte FIFO toward the TCP stack
// Assumes: TCP stack, knob logic and current ADC all run on ref_clk
// Notes:   Unknown codes are dropped; the parser resyncs on the next start byte
`timescale 1ns/1ns

module atcp_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // Drain side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);
  initial if (D < 2 || (1 << AW) != D) $error("atcp_fifo: depth must be a power of two");

  logic [W-1:0] mem [D];
  logic [AW:0]  wrPtr_q;
  logic [AW:0]  rdPtr_q;
  logic         full;
  logic         empty;

  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty    = wrPtr_q == rdPtr_q;
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && !full) wrPtr_q <= wrPtr_q + 1'b1;
      if (outReady && !empty) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule : atcp_fifo

module atcp_core import atcp_pkg::*; #(
  parameter int         PERIOD_CYC  = STATUS_PERIOD_CYC,
  parameter bit         HAS_DIR     = 1'b1,
  parameter logic [6:0] FW_VERSION  = 7'h01   // Arbitrary value
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Session control from the TCP stack
  input  wire logic        connReq,
  input  wire logic        sessClose,
  output logic             connAccept,
  output logic             connReject,
  output logic             sessOpen,
  output logic [15:0]      listenPort,
  // Received command bytes
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  output logic             rxReady,
  // Transmit bytes
  output logic             txValid,
  output logic [7:0]       txData,
  input  wire logic        txReady,
  // Local controls and measurement
  input  wire logic        localChange,
  input  wire logic [7:0]  localAtt,
  input  wire logic [7:0]  currentMa,
  input  wire logic        reprogramDone,
  // Applied settings and status
  output logic [15:0]      tuning_frequency_word,
  output logic [7:0]       attenuation_setting,
  output logic [7:0]       dirPosition,
  output logic             fullRange,
  output logic             lowRange,
  output logic             shortFault,
  output logic             openFault,
  output logic [7:0]       versionByte
);
  initial if (PERIOD_CYC < 2) $error("atcp_core: status period too short");

  typedef enum logic [1:0] {P_START, P_CODE, P_ARG1, P_ARG2} atcp_pst_t;
  typedef enum logic       {T_IDLE, T_SEND} atcp_tst_t;

  atcp_pst_t   pState_q;
  atcp_tst_t   tState_q;
  logic [7:0]  code_q;
  logic [7:0]  arg1_q;
  logic        sess_q;
  logic [31:0] tick_q;
  logic        tickHit;
  logic        statusPend_q;
  logic        verPend_q;
  logic        isVer_q;
  logic [3:0]  idx_q;
  logic [3:0]  frameLen;
  logic        pushValid;
  logic [7:0]  pushByte;
  logic        pushReady;
  logic        lastByte;
  logic        cmdApply;
  logic        bank_q;
  logic [7:0]  curRep;
  logic        shortPrev_q;
  logic        openPrev_q;
  logic        faultEvent;
  logic        fifoRstN;

  // Three-byte codes take one argument, frequency takes two
  function automatic logic isTwoArg(input logic [7:0] c);
    return c == CMD_TUNING_FREQUENCY_WORD;
  endfunction : isTwoArg

  // -------------------------------------------------------------
  // Session
  // -------------------------------------------------------------
  assign connAccept = connReq && !sess_q;
  assign connReject = connReq && sess_q;
  assign sessOpen   = sess_q;
  assign listenPort = TCP_PORT;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) sess_q <= 1'b0;
    else if (connAccept) sess_q <= 1'b1;
    else if (sessClose) sess_q <= 1'b0;
  end

  // -------------------------------------------------------------
  // Command parser
  // -------------------------------------------------------------
  // Accepting every byte keeps a stray client from wedging the stack
  assign rxReady  = 1'b1;
  assign cmdApply = rxValid && sess_q
                    && ((pState_q == P_ARG1 && !isTwoArg(code_q)) || pState_q == P_ARG2);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !sess_q) begin
      pState_q <= P_START;
      code_q   <= 8'h00;
      arg1_q   <= 8'h00;
    end else if (rxValid) begin
      case (pState_q)
        P_START: if (rxData == FRAME_START) pState_q <= P_CODE;
        P_CODE: begin
          code_q   <= rxData;
          pState_q <= (rxData == CMD_VERSION || rxData == CMD_TUNING_FREQUENCY_WORD || rxData == CMD_ATT
                       || (HAS_DIR && rxData == CMD_DIR)) ? P_ARG1 : P_START;
        end
        P_ARG1: begin
          arg1_q   <= rxData;
          pState_q <= isTwoArg(code_q) ? P_ARG2 : P_START;
        end
        P_ARG2:  pState_q <= P_START;
        default: pState_q <= P_START;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tuning_frequency_word <= RST_TUNING_FREQUENCY_WORD;
      attenuation_setting   <= RST_ATT;
      dirPosition           <= RST_POS;
    end else if (cmdApply) begin
      if (code_q == CMD_TUNING_FREQUENCY_WORD) tuning_frequency_word <= {rxData, arg1_q};
      if (code_q == CMD_ATT) attenuation_setting <= rxData;
      if (code_q == CMD_DIR && rxData <= POS_MAX) dirPosition <= rxData;
    end else if (localChange) begin
      attenuation_setting <= localAtt;
    end
  end

  assign fullRange = tuning_frequency_word < TUNING_FREQUENCY_WORD_LOW_KHZ
                     || tuning_frequency_word > TUNING_FREQUENCY_WORD_HIGH_KHZ;
  assign lowRange  = tuning_frequency_word == TUNING_FREQUENCY_WORD_LOW_KHZ;

  // -------------------------------------------------------------
  // Firmware bank and faults
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) bank_q <= 1'b0;
    else if (reprogramDone) bank_q <= !bank_q;
  end
  assign versionByte = {bank_q, FW_VERSION};

  assign curRep     = (currentMa < FLOOR_MA) ? 8'h00 : currentMa;
  assign shortFault = currentMa > SHORT_MA;
  assign openFault  = curRep == 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shortPrev_q <= 1'b0;
      openPrev_q  <= 1'b0;
    end else begin
      shortPrev_q <= shortFault;
      openPrev_q  <= openFault;
    end
  end
  assign faultEvent = (shortFault && !shortPrev_q) || (openFault && !openPrev_q);

  // -------------------------------------------------------------
  // Reporting schedule
  // -------------------------------------------------------------
  assign tickHit = tick_q == 32'(PERIOD_CYC - 1);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !sess_q || tickHit) tick_q <= 32'h0;
    else tick_q <= tick_q + 32'h1;
  end

  // A new event wins over the clear of a pending report
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !sess_q) begin
      statusPend_q <= 1'b0;
      verPend_q    <= 1'b0;
    end else begin
      if (tickHit || localChange || faultEvent
          || (cmdApply && code_q != CMD_VERSION)) statusPend_q <= 1'b1;
      else if (tState_q == T_IDLE && !verPend_q) statusPend_q <= 1'b0;
      if (cmdApply && code_q == CMD_VERSION && rxData == 8'h00) verPend_q <= 1'b1;
      else if (tState_q == T_IDLE) verPend_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // Framer into the FIFO
  // -------------------------------------------------------------
  assign frameLen = isVer_q ? LEN_VERSION : (HAS_DIR ? LEN_STATUS_DIR : LEN_STATUS);
  assign lastByte = idx_q == frameLen - 4'h1;
  assign pushValid = tState_q == T_SEND;

  always_comb begin
    pushByte = FRAME_START;
    if (isVer_q) begin
      case (idx_q)
        4'h1:    pushByte = VER_TAG;
        4'h2:    pushByte = versionByte;
        default: pushByte = FRAME_START;
      endcase
    end else begin
      case (idx_q)
        4'h1:    pushByte = ST_TAG_CURRENT;
        4'h2:    pushByte = curRep;
        4'h4:    pushByte = ST_TAG_TUNING_FREQUENCY_WORD;
        4'h5:    pushByte = tuning_frequency_word[7:0];
        4'h6:    pushByte = tuning_frequency_word[15:8];
        4'h7:    pushByte = attenuation_setting;
        4'h9:    pushByte = ST_TAG_DIR;
        4'ha:    pushByte = dirPosition;
        default: pushByte = FRAME_START;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !sess_q) begin
      tState_q <= T_IDLE;
      idx_q    <= 4'h0;
      isVer_q  <= 1'b0;
    end else begin
      case (tState_q)
        T_IDLE: if (verPend_q || statusPend_q) begin
          tState_q <= T_SEND;
          isVer_q  <= verPend_q;
          idx_q    <= 4'h0;
        end
        T_SEND: if (pushReady) begin
          idx_q <= idx_q + 4'h1;
          if (lastByte) tState_q <= T_IDLE;
        end
        default: tState_q <= T_IDLE;
      endcase
    end
  end

  // Flush on close so a cut frame never reaches the next client
  assign fifoRstN = rst_n && sess_q;

  atcp_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) uFifo (
    .ref_clk  (ref_clk),
    .rst_n    (fifoRstN),
    .inValid  (pushValid),
    .inData   (pushByte),
    .inReady  (pushReady),
    .outValid (txValid),
    .outData  (txData),
    .outReady (txReady)
  );

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  logic push;
  assign push = pushValid && pushReady;

  sequence s_freqCmd;
    cmdApply && code_q == CMD_TUNING_FREQUENCY_WORD;
  endsequence

  property p_one_session;
    @(posedge ref_clk) disable iff (!rst_n)
      connReq && sess_q && !sessClose |=> sess_q && !connAccept[*1];
  endproperty
  a_one_session: assert property (p_one_session) else $error("second session accepted");

  property p_tick_sets;
    @(posedge ref_clk) disable iff (!rst_n) tickHit && sess_q |=> statusPend_q;
  endproperty
  a_tick_sets: assert property (p_tick_sets) else $error("periodic status lost");

  property p_event_sends;
    @(posedge ref_clk) disable iff (!rst_n)
      (localChange || faultEvent) && sess_q && !sessClose |=> ##[0:24] tState_q == T_SEND;
  endproperty
  a_event_sends: assert property (p_event_sends) else $error("event not reported");

  property p_cmd_confirm;
    @(posedge ref_clk) disable iff (!rst_n)
      s_freqCmd |=> statusPend_q && tuning_frequency_word == {$past(rxData), $past(arg1_q)};
  endproperty
  a_cmd_confirm: assert property (p_cmd_confirm) else $error("command not confirmed");

  property p_status_hdr;
    @(posedge ref_clk) disable iff (!rst_n)
      push && !isVer_q && idx_q == 4'h0 ##1 push[*1] |-> pushByte == ST_TAG_CURRENT;
  endproperty
  a_status_hdr: assert property (p_status_hdr) else $error("bad status header");

  property p_low_range;
    @(posedge ref_clk) disable iff (!rst_n) s_freqCmd ##0 (rxData == 8'h01 && arg1_q == 8'hf4)
      |=> lowRange && !fullRange;
  endproperty
  a_low_range: assert property (p_low_range) else $error("500 kHz not low range");

  property p_floor;
    @(posedge ref_clk) disable iff (!rst_n)
      push && !isVer_q && idx_q == 4'h2 && currentMa < FLOOR_MA |-> pushByte == 8'h00;
  endproperty
  a_floor: assert property (p_floor) else $error("small current reported");

  property p_short;
    @(posedge ref_clk) disable iff (!rst_n) currentMa > SHORT_MA |-> shortFault && !openFault;
  endproperty
  a_short: assert property (p_short) else $error("short not flagged");

  property p_version;
    @(posedge ref_clk) disable iff (!rst_n)
      push && isVer_q && idx_q == 4'h1 |=> !push || pushByte == {bank_q, FW_VERSION};
  endproperty
  a_version: assert property (p_version) else $error("bad version byte");

  property p_bank;
    @(posedge ref_clk) disable iff (!rst_n) reprogramDone |=> bank_q != $past(bank_q);
  endproperty
  a_bank: assert property (p_bank) else $error("bank not toggled");
endmodule : atcp_core

// >>> atcp_pkg.sv
// Purpose: Constants for the antenna command interpreter and status reporter
// Assumes: One 125 MHz clock; byte streams come from a TCP stack on that clock
// Notes:   Frame bytes, thresholds and timing live here only
//
// Notes on behaviour
// - Serve one session; refuse further connection requests
// - Send status about twice per second
// - Local change or fault sends status immediately
// - Applied command triggers confirming status packet
// - Status: 0d 08 current 0d 0a freqLo freqHi att
// - Frequency is 16-bit, low byte first, 1 kHz
// - Attenuation byte in half-decibel steps, command b4
// - Short above 200 mA, break at zero
// - Currents below 20 mA report as zero
// - Direction variant appends 0d 09 position
// - Position 0..231; zero off, 231 is 180 degrees
// - Request 0d 12 00 answers 0d ff version
// - Version byte: bank bit 7, number bits 6:0
// - Toggle firmware bank after each reprogramming
// - Below 500 or above 30000 kHz: full range
// - Exactly 500 kHz selects low range
// - Direction command 0d b2 position accepted
// - Commands must arrive whole; parser waits otherwise
// - Server listens on port 55556
package atcp_pkg;
  localparam logic [7:0]  FRAME_START    = 8'h0d;
  localparam logic [7:0]  ST_TAG_CURRENT = 8'h08;
  localparam logic [7:0]  ST_TAG_TUNING_FREQUENCY_WORD    = 8'h0a;
  localparam logic [7:0]  ST_TAG_DIR     = 8'h09;
  localparam logic [7:0]  VER_TAG        = 8'hff;
  localparam logic [7:0]  CMD_VERSION    = 8'h12;
  localparam logic [7:0]  CMD_TUNING_FREQUENCY_WORD       = 8'hb0;
  localparam logic [7:0]  CMD_DIR        = 8'hb2;
  localparam logic [7:0]  CMD_ATT        = 8'hb4;
  localparam logic [15:0] TCP_PORT       = 16'hd904;   // 55556
  localparam logic [15:0] TUNING_FREQUENCY_WORD_LOW_KHZ   = 16'h01f4;   // 500
  localparam logic [15:0] TUNING_FREQUENCY_WORD_HIGH_KHZ  = 16'h7530;   // 30000
  localparam logic [7:0]  SHORT_MA       = 8'hc8;      // 200
  localparam logic [7:0]  FLOOR_MA       = 8'h14;      // 20
  localparam logic [7:0]  POS_MAX        = 8'he7;      // 231
  localparam logic [3:0]  LEN_STATUS     = 4'h8;
  localparam logic [3:0]  LEN_STATUS_DIR = 4'hb;
  localparam logic [3:0]  LEN_VERSION    = 4'h3;
  localparam logic [7:0]  RST_ATT        = 8'h00;
  localparam logic [15:0] RST_TUNING_FREQUENCY_WORD       = 16'h0000;
  localparam logic [7:0]  RST_POS        = 8'h00;
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          STATUS_PERIOD_MS = 500;
  localparam int          STATUS_PERIOD_CYC = STATUS_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          FIFO_WIDTH     = 8;
endpackage : atcp_pkg

// >>> atcp_client_model.sv
// Purpose: Remote client model that feeds command bytes and collects device bytes
// Assumes: Commands are sent whole, one byte per cycle
// Notes:   Slow mode stalls the device side in a fixed irregular pattern
`timescale 1ns/1ns

module atcp_client_model (
  // Clock
  input  wire logic       ref_clk,
  // Bytes from the device
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // Bytes toward the device
  output logic            rxValid,
  output logic [7:0]      rxData,
  // Stall mode
  input  wire logic       slow
);
  logic [7:0] got[$];
  logic [3:0] cnt;

  initial begin
    txReady = 1'b1;
    rxValid = 1'b0;
    rxData  = 8'h00;
    cnt     = 4'h0;
  end

  always @(posedge ref_clk) begin
    if (txValid && txReady) begin
      got.push_back(txData);
    end
  end

  always @(negedge ref_clk) begin
    cnt     <= cnt + 4'h1;
    txReady <= !slow || (cnt[0] ^ cnt[2]);
  end

  // Whole frames only, never split; idle data is the inverted last byte
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(negedge ref_clk);
      rxValid = 1'b1;
      rxData  = b[i];
    end
    @(negedge ref_clk);
    rxValid = 1'b0;
    rxData  = ~rxData;
  endtask : send
endmodule : atcp_client_model

// >>> tb_top.sv
// Purpose: Self-checking bench for the antenna command interpreter
// Assumes: Short status period; client model collects every sent byte
// Notes:   Frames are parsed in alignment and compared with a bench model
`timescale 1ns/1ns

module tb_top import atcp_pkg::*; ;
  localparam int         PER = 1000;
  localparam logic [6:0] FWV = 7'h2a;  // Arbitrary value
  logic        refClk = 1'b0;
  logic        rstN, connReq, sessClose, localChange, reprogramDone, slow;
  logic        rxValid, rxReady, txValid, txReady, connAccept, connReject, sessOpen;
  logic        fullRange, lowRange, shortFault, openFault;
  logic [7:0]  rxData, txData, localAtt, currentMa, attSet, dirPos, verByte, pos8;
  logic [15:0] listenPort, freqWord;
  logic [31:0] seed = 32'h1ac2;
  logic [31:0] r;
  logic [15:0] fv[6] = '{16'h01f3, 16'h01f4, 16'h01f5, 16'h7530, 16'h7531, 16'h0000};
  logic [7:0]  ct[4] = '{8'h13, 8'h14, 8'hc8, 8'hc9};
  int          miscompares, n_checks, cycles, mFreq, mAtt, mPos, mBank, ns, nv, k;

  always #4 refClk = ~refClk;

  atcp_core #(.PERIOD_CYC(PER), .HAS_DIR(1'b1), .FW_VERSION(FWV)) atcp_core_i (
    .ref_clk(refClk), .rst_n(rstN), .connReq(connReq), .sessClose(sessClose),
    .connAccept(connAccept), .connReject(connReject), .sessOpen(sessOpen),
    .listenPort(listenPort), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
    .txValid(txValid), .txData(txData), .txReady(txReady), .localChange(localChange),
    .localAtt(localAtt), .currentMa(currentMa), .reprogramDone(reprogramDone),
    .tuning_frequency_word(freqWord), .attenuation_setting(attSet), .dirPosition(dirPos),
    .fullRange(fullRange), .lowRange(lowRange), .shortFault(shortFault),
    .openFault(openFault), .versionByte(verByte));

  atcp_client_model atcp_client_model_i (
    .ref_clk(refClk), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxValid(rxValid), .rxData(rxData), .slow(slow));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      end_sim();
    end
  end

  function automatic logic [7:0] expSt(input int j);
    logic [7:0] t[11];
    logic [7:0] cur;
    cur = (currentMa < 8'h14) ? 8'h00 : currentMa;
    t = '{8'h0d, 8'h08, cur, 8'h0d, 8'h0a, mFreq[7:0], mFreq[15:8], mAtt[7:0],
          8'h0d, 8'h09, mPos[7:0]};
    return t[j];
  endfunction : expSt

  // Bounded wait for the device to fall quiet
  task automatic settle(input int min);
    int i;
    for (i = 0; i < 400; i++) begin
      @(negedge refClk);
      if (i > 20 && txValid === 1'b0 && atcp_client_model_i.got.size() >= min) break;
    end
  endtask : settle

  task automatic frames();
    int i;
    int j;
    ns = 0;
    nv = 0;
    i = 0;
    while (i + 2 < atcp_client_model_i.got.size()) begin
      if (atcp_client_model_i.got[i+1] === 8'hff) begin
        check("ver start", atcp_client_model_i.got[i], 8'h0d);
        check("ver byte", atcp_client_model_i.got[i+2], {mBank[0], FWV});
        nv++;
        i += 3;
      end else begin
        for (j = 0; j < 11; j++) begin
          check("status byte", atcp_client_model_i.got[i+j], expSt(j));
        end
        ns++;
        i += 11;
      end
    end
    check("frame end", i, atcp_client_model_i.got.size());
    atcp_client_model_i.got.delete();
  endtask : frames

  initial begin
    {rstN, connReq, sessClose, localChange, reprogramDone, slow} = 6'h00;
    localAtt = 8'h00;
    currentMa = 8'h64;
    {mFreq, mAtt, mPos, mBank} = '0;
    repeat (16) @(negedge refClk);
    rstN = 1'b1;
    check("sessOpen", sessOpen, 1'b0);
    check("fullRange", fullRange, 1'b1);
    check("port", listenPort, 16'hd904);
    check("rxReady", rxReady, 1'b1);
    check("version", verByte, {1'b0, FWV});
    connReq = 1'b1;
    #1 check("accept", connAccept, 1'b1);
    @(negedge refClk);
    #1 check("open", sessOpen, 1'b1);
    check("reject", connReject, 1'b1);
    check("no accept", connAccept, 1'b0);
    @(negedge refClk);
    connReq = 1'b0;
    $display("test session done");
    r = rnd();
    fv[5] = r[15:0];
    foreach (fv[i]) begin
      mFreq = fv[i];
      slow = (i > 2);
      atcp_client_model_i.send('{8'h0d, 8'hb0, fv[i][7:0], fv[i][15:8]});
      settle(11);
      check("tuning_frequency_word", freqWord, fv[i]);
      check("full", fullRange, fv[i] < 16'h01f4 || fv[i] > 16'h7530);
      check("low", lowRange, fv[i] == 16'h01f4);
      frames();
      check("confirm", ns > 0, 1'b1);
    end
    $display("test frequency done");
    for (k = 0; k < 4; k++) begin
      r = rnd();
      mAtt = r[7:0];
      pos8 = (k == 0) ? 8'he7 : (k == 3) ? 8'he8 : 8'(r[15:8] % 232);
      mPos = (pos8 > 8'he7) ? mPos : pos8;
      atcp_client_model_i.send('{8'h0d, 8'hb4, r[7:0], 8'h0d, 8'hb2, pos8});
      settle(11);
      check("att", attSet, mAtt[7:0]);
      check("pos", dirPos, mPos[7:0]);
      frames();
      check("confirm", ns > 0, 1'b1);
    end
    $display("test attenuation and direction done");
    for (k = 0; k < 2; k++) begin
      atcp_client_model_i.send('{8'h0d, 8'h12, 8'h00});
      settle(3);
      frames();
      check("ver reply", nv, 1);
      reprogramDone = 1'b1;
      @(negedge refClk);
      reprogramDone = 1'b0;
      mBank = mBank ^ 1;
      check("bank", verByte, {mBank[0], FWV});
    end
    $display("test version done");
    localAtt = 8'h3c;
    localChange = 1'b1;
    @(negedge refClk);
    localChange = 1'b0;
    mAtt = 8'h3c;
    settle(11);
    frames();
    check("local event", ns > 0, 1'b1);
    foreach (ct[i]) begin
      currentMa = ct[i];
      #1 check("open fault", openFault, ct[i] < 8'h14);
      check("short fault", shortFault, ct[i] > 8'hc8);
      settle((ct[i] < 8'h14 || ct[i] > 8'hc8) ? 11 : 0);
      frames();
      if (ct[i] < 8'h14 || ct[i] > 8'hc8) check("fault event", ns > 0, 1'b1);
    end
    $display("test faults done");
    repeat (5 * PER) @(negedge refClk);
    settle(0);
    frames();
    check("periodic", ns >= 4 && ns <= 6, 1'b1);
    $display("test periodic done");
    sessClose = 1'b1;
    @(negedge refClk);
    sessClose = 1'b0;
    check("closed", sessOpen, 1'b0);
    atcp_client_model_i.send('{8'h0d, 8'hb4, 8'h77});
    settle(0);
    check("att closed", attSet, mAtt[7:0]);
    check("silent", atcp_client_model_i.got.size(), 0);
    $display("test close done");
    end_sim();
  end
endmodule : tb_top
